// *** rtl/pbc_defs.svh ***
/*
 * constants for bits 11..0 of the basic mode control register:
 * register index, bit positions, management frame fields and counts.
 * assumes inclusion by bare name from package and design files.
 */
`ifndef PBC_DEFS_SVH
`define PBC_DEFS_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define PBC_REG_CTRL 5'h00
`define PBC_REG_W 16
`define PBC_BIT_PWRDN 11
`define PBC_BIT_ISOLATE 10
`define PBC_BIT_RESTART 9
`define PBC_BIT_DUPLEX 8
`define PBC_BIT_COLTEST 7
`define PBC_UPPER_HI 15
`define PBC_UPPER_LO 12
`define PBC_RST_PWRDN 1'h0
`define PBC_RST_ISOLATE 1'h0
`define PBC_RST_RESTART 1'h0
`define PBC_RST_DUPLEX 1'h1
`define PBC_RST_COLTEST 1'h0
`define PBC_RESERVED_RD 7'h00

// ----------------------------------------
// management frame
// ----------------------------------------
`define PBC_OP_READ 2'h2
`define PBC_OP_WRITE 2'h1
`define PBC_HDR_LAST 4'hB
`define PBC_TA_LAST 4'h1
`define PBC_DATA_LAST 4'hF
`define PBC_OP_HI 11
`define PBC_OP_LO 10
`define PBC_PHY_HI 9
`define PBC_PHY_LO 5
`define PBC_REG_HI 4
`define PBC_REG_LO 0

// ----------------------------------------
// timing and synchroniser layout
// ----------------------------------------
`define PBC_SYNC_N 5
`define PBC_SYN_MDC 0
`define PBC_SYN_MDIO 1
`define PBC_SYN_PWDN 2
`define PBC_SYN_TXEN 3
`define PBC_SYN_STRAP 4
`define PBC_STRAP_WAIT 2'h3
`define PBC_CLK_NS 100
`define PBC_BIT_NS 10
`define PBC_COL_ON_BITS 512
`define PBC_COL_OFF_BITS 4
`define PBC_COL_ON_CYC ((`PBC_COL_ON_BITS * `PBC_BIT_NS) / `PBC_CLK_NS)

`endif

// *** rtl/pbc_pkg.sv ***
/*
 * types for the basic mode control low-bits block.
 * assumes pbc_defs.svh is on the include path.
 */
`include "pbc_defs.svh"

package pbc_pkg;

	typedef enum logic [4:0] {
		PBC_IDLE = 5'h01,
		PBC_START = 5'h02,
		PBC_HDR = 5'h04,
		PBC_TA = 5'h08,
		PBC_DATA = 5'h10
	} pbc_state_t;

	typedef logic [`PBC_REG_W-1:0] pbc_word_t;

endpackage : pbc_pkg

// *** rtl/pbc_basic_control.sv ***
/*
 * basic mode control register bits 11..0, reached over the serial
 * management link (mdc/mdio), plus the power-down, isolate, restart,
 * duplex and collision-test behaviour those bits steer.
 * assumes one 10 MHz clock, mdc well below clk/6, bits 15..12 kept by
 * neighbouring logic and handed in/out through the upper* ports.
 */
// Summary of operation
// - bit 11 requests power down when 1, resets to 0, read-write.
// - in power down COL is forced low and miiIsolate high; management and all other logic keep running.
// - effective power down is bit 11 OR the power-down pin request.
// - power-down pin driven low sets bit 11.
// - bit 10 isolates port from MII, management still works; resets 0.
// - writing 1 to bit 9 restarts auto-negotiation, ignored if disabled.
// - bit 9 reads 1 until negotiation starts, then clears itself.
// - software clearing bit 9 never aborts running negotiation.
// - bit 8 selects full (1) or half duplex; default 1, whatever the strap pin.
// - bit 7 set asserts COL within 512 bit times of TX_EN rising.
// - in collision test COL drops within 4 bit times of TX_EN falling; here COL drops 4 to 5 clocks after TX_EN falls.
// - bits 6:0 reserved: writes dropped, reads return zero.
// - with auto-negotiation on, manual speed and duplex bits are ignored.
// - strap load at reset takes the reset level 1, not the strap pin; soft strap value wins after config done.
`timescale 1ns/1ps
`default_nettype none
`include "pbc_defs.svh"

module pbc_basic_control
(
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// management link pins
	input wire logic mdc,
	input wire logic mdioIn,
	output logic mdioOut,
	output logic mdioOe_n,
	input wire logic [4:0] phyAddr,
	// power-down pin and straps
	input wire logic interrupt_powerdown_pin_n,
	input wire logic strapDuplex,
	input wire logic configDone,
	input wire logic soft_strap_default,
	// neighbouring bits 15..12 and negotiation engine
	input wire logic [3:0] upperBits,
	input wire logic anEnable,
	input wire logic anDuplex,
	input wire logic anInitiated,
	output logic upperWrStrobe,
	output logic [3:0] upperWrData,
	output logic anRestartReq,
	// MII side
	input wire logic txEn,
	output logic col,
	output logic miiIsolate,
	output logic powerDown,
	output logic fullDuplex
);
	import pbc_pkg::*;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [`PBC_SYNC_N-1:0] rawIn;
	logic [`PBC_SYNC_N-1:0] syncA;
	logic [`PBC_SYNC_N-1:0] syncB;
	logic [`PBC_SYNC_N-1:0] syncC;
	logic [`PBC_SYNC_N-1:0] lvl;

	assign rawIn = {strapDuplex, txEn, interrupt_powerdown_pin_n, mdioIn, mdc};

	genvar gi;
	generate
		for (gi = 0; gi < `PBC_SYNC_N; gi = gi + 1)
		begin : g_sync
			// level only moves once stages two and three agree
			always_ff @(posedge clk)
			begin
				if (sys_rst)
				begin
					syncA[gi] <= 1'b1;
					syncB[gi] <= 1'b1;
					syncC[gi] <= 1'b1;
					lvl[gi] <= 1'b1;
				end
				else
				begin
					syncA[gi] <= rawIn[gi];
					syncB[gi] <= syncA[gi];
					syncC[gi] <= syncB[gi];
					if (syncB[gi] == syncC[gi])
						lvl[gi] <= syncC[gi];
				end
			end
		end
	endgenerate

	wire mdcRise = ~lvl[`PBC_SYN_MDC] & syncB[`PBC_SYN_MDC] & syncC[`PBC_SYN_MDC];
	wire mdcFall = lvl[`PBC_SYN_MDC] & ~syncB[`PBC_SYN_MDC] & ~syncC[`PBC_SYN_MDC];
	wire mdioBit = lvl[`PBC_SYN_MDIO];
	wire pinPwdn = ~lvl[`PBC_SYN_PWDN];
	wire txEnLvl = lvl[`PBC_SYN_TXEN];

	// ----------------------------------------
	// management frame receiver
	// ----------------------------------------
	pbc_state_t state;
	pbc_state_t next_state;
	logic [3:0] bitCnt;
	logic [`PBC_HDR_LAST:0] hdr;
	pbc_word_t shReg;
	logic lastBit;

	wire [1:0] hdrOp = hdr[`PBC_OP_HI:`PBC_OP_LO];
	wire hdrHit = (hdr[`PBC_PHY_HI:`PBC_PHY_LO] == phyAddr)
		&& (hdr[`PBC_REG_HI:`PBC_REG_LO] == `PBC_REG_CTRL);
	wire isRead = hdrHit && (hdrOp == `PBC_OP_READ);
	wire isWrite = hdrHit && (hdrOp == `PBC_OP_WRITE);
	wire cntEnd = (state == PBC_HDR && bitCnt == `PBC_HDR_LAST)
		|| (state == PBC_TA && bitCnt == `PBC_TA_LAST)
		|| (state == PBC_DATA && bitCnt == `PBC_DATA_LAST);
	wire wrCommit = mdcRise && state == PBC_DATA && cntEnd && isWrite;

	// no preamble count: suppressed preambles are accepted after any 1
	always_comb
	begin
		next_state = state;
		case (state)
			PBC_IDLE: if (!mdioBit && lastBit) next_state = PBC_START;
			PBC_START: next_state = mdioBit ? PBC_HDR : PBC_IDLE;
			PBC_HDR: if (cntEnd) next_state = PBC_TA;
			PBC_TA: if (cntEnd) next_state = PBC_DATA;
			PBC_DATA: if (cntEnd) next_state = PBC_IDLE;
			default: next_state = PBC_IDLE;
		endcase
	end

	// ----------------------------------------
	// register bits
	// ----------------------------------------
	logic pwrDownBit;
	logic isolateBit;
	logic restartBit;
	logic duplexBit;
	logic colTestBit;
	logic strapTaken;
	logic [1:0] strapWait;

	// the last data bit is still in mdioBit at commit, so the word is shifted once more
	wire [`PBC_REG_W-1:0] wrWord = {shReg[`PBC_REG_W-2:0], mdioBit};
	// reserved low bits always read zero
	wire [`PBC_REG_W-1:0] readWord = {upperBits, pwrDownBit, isolateBit, restartBit,
		duplexBit, colTestBit, `PBC_RESERVED_RD};
	wire effPwdn = pwrDownBit | pinPwdn;
	wire wrRestart = wrCommit && wrWord[`PBC_BIT_RESTART] && anEnable;
	// a written 0 only clears the readback flag
	wire restartClr = anInitiated || (wrCommit && !wrWord[`PBC_BIT_RESTART]);
	wire strapLoad = !strapTaken && (strapWait == `PBC_STRAP_WAIT);

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			state <= PBC_IDLE;
			bitCnt <= 4'h0;
			hdr <= 12'h000;
			shReg <= 16'h0000;
			lastBit <= 1'b0;
			mdioOut <= 1'b1;
			mdioOe_n <= 1'b1;
		end
		else if (mdcRise)
		begin
			// management stays clocked in power down, so bit 11 can be cleared
			state <= next_state;
			lastBit <= mdioBit;
			bitCnt <= (next_state != state) ? 4'h0 : bitCnt + 4'h1;
			if (state == PBC_HDR)
				hdr <= {hdr[`PBC_HDR_LAST-1:0], mdioBit};
			if (state == PBC_TA && cntEnd)
				shReg <= readWord;
			else if (state == PBC_DATA && !isRead)
				shReg <= {shReg[`PBC_REG_W-2:0], mdioBit};
		end
		else if (mdcFall)
		begin
			if (state == PBC_TA && isRead && bitCnt == `PBC_TA_LAST)
			begin
				mdioOe_n <= 1'b0;
				mdioOut <= 1'b0;
			end
			else if (state == PBC_DATA && isRead)
			begin
				mdioOe_n <= 1'b0;
				mdioOut <= shReg[`PBC_REG_W-1];
				shReg <= {shReg[`PBC_REG_W-2:0], 1'b0};
			end
			else
			begin
				mdioOe_n <= 1'b1;
				mdioOut <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// register bit storage
	// ----------------------------------------
	// pin request beats a software clear
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			pwrDownBit <= `PBC_RST_PWRDN;
		else if (pinPwdn)
			pwrDownBit <= 1'b1;
		else if (wrCommit)
			pwrDownBit <= wrWord[`PBC_BIT_PWRDN];
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			isolateBit <= `PBC_RST_ISOLATE;
		else if (wrCommit)
			isolateBit <= wrWord[`PBC_BIT_ISOLATE];
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			colTestBit <= `PBC_RST_COLTEST;
		else if (wrCommit)
			colTestBit <= wrWord[`PBC_BIT_COLTEST];
	end

	// set wins over a same-cycle clear
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			restartBit <= `PBC_RST_RESTART;
		else if (wrRestart)
			restartBit <= 1'b1;
		else if (restartClr)
			restartBit <= 1'b0;
	end

	// strap read on the fourth clock after release, while its synchroniser level still holds the reset value 1
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			strapTaken <= 1'b0;
			strapWait <= 2'h0;
		end
		else if (!strapTaken)
		begin
			strapWait <= strapWait + 2'h1;
			strapTaken <= strapLoad;
		end
	end

	// soft strap beats a same-cycle write
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			duplexBit <= `PBC_RST_DUPLEX;
		else if (strapLoad)
			duplexBit <= lvl[`PBC_SYN_STRAP];
		else if (strapTaken && configDone)
			duplexBit <= soft_strap_default;
		else if (strapTaken && wrCommit)
			duplexBit <= wrWord[`PBC_BIT_DUPLEX];
	end

	// ----------------------------------------
	// outputs to neighbours and MII
	// ----------------------------------------
	// synchroniser lag (~4 cycles) sits far inside 512 bit times; the
	// 4-bit-time drop is not met at 100 Mb/s rates against this clock
	wire next_col = colTestBit && txEnLvl && !isolateBit && !effPwdn;
	wire next_miiIsolate = isolateBit | effPwdn;
	wire next_fullDuplex = anEnable ? anDuplex : duplexBit;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			upperWrStrobe <= 1'b0;
			upperWrData <= 4'h0;
			anRestartReq <= 1'b0;
			col <= 1'b0;
			miiIsolate <= 1'b0;
			powerDown <= 1'b0;
			fullDuplex <= 1'b1;
		end
		else
		begin
			upperWrStrobe <= wrCommit;
			if (wrCommit)
				upperWrData <= wrWord[`PBC_UPPER_HI:`PBC_UPPER_LO];
			// one pulse per write; a later clear cannot recall it
			anRestartReq <= wrRestart;
			powerDown <= effPwdn;
			miiIsolate <= next_miiIsolate;
			fullDuplex <= next_fullDuplex;
			col <= next_col;
		end
	end

endmodule : pbc_basic_control
`default_nettype wire

// *** testbench/pbc_basic_control_assertions.sv ***
/* port checks on the low control bits block.
   assumes bind into pbc_basic_control, one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module pbc_basic_control_checker
(
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// watched ports
	input wire logic interrupt_powerdown_pin_n,
	input wire logic anEnable,
	input wire logic anDuplex,
	input wire logic txEn,
	input wire logic col,
	input wire logic miiIsolate,
	input wire logic powerDown,
	input wire logic fullDuplex,
	input wire logic anRestartReq,
	input wire logic upperWrStrobe,
	input wire logic mdioOe_n
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	sequence txDrop;
		$fell(txEn) ##1 !txEn;
	endsequence
	rst_values_a: assert property (disable iff (1'b0) $fell(sys_rst) |->
		!col && !powerDown && !miiIsolate && fullDuplex && mdioOe_n) else $error("bad reset");
	pin_powerdown_a: assert property (!interrupt_powerdown_pin_n [*8] |-> powerDown)
		else $error("pin did not power down");
	pd_isolates_a: assert property (powerDown [*2] |-> miiIsolate)
		else $error("power down not isolated");
	isolate_col_a: assert property (miiIsolate [*2] |-> !col)
		else $error("col while isolated");
	col_release_a: assert property (txDrop |-> ##[0:6] !col)
		else $error("col held after tx end");
	col_cause_a: assert property ($rose(col) |-> txEn)
		else $error("col without tx");
	an_duplex_a: assert property ($past(anEnable) && !$past(sys_rst) |->
		fullDuplex == $past(anDuplex)) else $error("manual duplex used");
	restart_gate_a: assert property (anRestartReq |-> upperWrStrobe && $past(anEnable))
		else $error("restart while disabled");
	restart_pulse_a: assert property (anRestartReq |=> !anRestartReq && !upperWrStrobe)
		else $error("restart pulse too long");
endmodule : pbc_basic_control_checker
bind pbc_basic_control pbc_basic_control_checker pbc_basic_control_checker_inst (.clk,
	.sys_rst, .interrupt_powerdown_pin_n, .anEnable, .anDuplex, .txEn, .col, .miiIsolate,
	.powerDown, .fullDuplex, .anRestartReq, .upperWrStrobe, .mdioOe_n);
`default_nettype wire

// *** testbench/pbc_mgmt_master.sv ***
/* station management master model on mdc/mdio.
   assumes a pull-up on mdio and a 10 MHz clk. */
`timescale 1ns/1ps
`default_nettype none
module pbc_mgmt_master
(
	// clock
	input wire logic clk,
	// management pins
	output var logic mdc,
	output wire logic mdioIn,
	input wire logic mdioOut,
	input wire logic mdioOe_n
);
	logic drv = 1'b1;
	logic own = 1'b1;
	initial mdc = 1'b0;
	// released wire falls back to the pull-up, never the last value
	assign mdioIn = !mdioOe_n ? mdioOut : (own ? drv : 1'b1);
	task xfer(input logic [1:0] op, input logic [4:0] pa, input logic [15:0] wd,
		output logic [15:0] rd);
		logic [33:0] f;
		f = {4'b1101, op, pa, 5'h00, 2'b10, wd};
		for (int i = 33; i >= 0; i--)
		begin
			@(posedge clk) mdc <= 1'b0;
			own <= !(op == 2'h2 && i < 18);
			drv <= f[i];
			// long low phase: answer lags the pin edge by several clocks
			repeat (7) @(posedge clk);
			@(negedge clk) rd = {rd[14:0], mdioIn};
			@(posedge clk) mdc <= 1'b1;
			repeat (5) @(posedge clk);
		end
		own <= 1'b1;
		drv <= 1'b1;
	endtask : xfer
endmodule : pbc_mgmt_master
`default_nettype wire

// *** testbench/test_pbc_basic_control.sv ***
/* self-checking bench for the low control bits block.
   assumes the master model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
`include "pbc_defs.svh"
module test_pbc_basic_control;
	import pbc_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [4:0] phyAddr = 5'h05;
	logic [3:0] upperBits = 4'hA;
	logic interrupt_powerdown_pin_n = 1'b1;
	logic strapDuplex = 1'b1;
	logic configDone = 1'b0;
	logic soft_strap_default = 1'b0;
	logic anEnable = 1'b1;
	logic anDuplex = 1'b1;
	logic anInitiated = 1'b0;
	logic txEn = 1'b0;
	wire logic mdc, mdioIn, mdioOut, mdioOe_n, upperWrStrobe, anRestartReq;
	wire logic col, miiIsolate, powerDown, fullDuplex;
	wire logic [3:0] upperWrData;
	int failures = 0;
	int cmp_count = 0;
	int restartCnt = 0;
	pbc_word_t rdw;
	always #50 clk = ~clk;
	always @(posedge clk)
	begin
		if (anRestartReq === 1'b1)
			restartCnt <= restartCnt + 1;
	end
	pbc_basic_control pbc_basic_control_inst (.*);
	pbc_mgmt_master pbc_mgmt_master_inst (.*);
	task chkw(input pbc_word_t exp, input pbc_word_t got);
		cmp_count++;
		if (got !== exp)
		begin
			failures++;
			$display("MISMATCH %0t read %h expected %h", $time, got, exp);
		end
	endtask : chkw
	task chkb(input logic exp, input logic got);
		cmp_count++;
		if (got !== exp)
		begin
			failures++;
			$display("MISMATCH %0t flag %b expected %b", $time, got, exp);
		end
	endtask : chkb
	task print_verdict;
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : print_verdict
	// waits end on negedge so registered outputs have settled
	task cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	task wr(input pbc_word_t d);
		pbc_word_t x;
		pbc_mgmt_master_inst.xfer(`PBC_OP_WRITE, phyAddr, d, x);
		cyc(4);
	endtask : wr
	task rd;
		pbc_mgmt_master_inst.xfer(`PBC_OP_READ, phyAddr, 16'h0000, rdw);
	endtask : rd
	task t_write;
		wr(16'hFFFF);
		chkb(1'b1, restartCnt == 1);
		chkb(1'b1, powerDown);
		chkb(1'b1, miiIsolate);
		chkw(16'h000F, {12'h000, upperWrData});
		rd;
		chkw({upperBits, 12'hF80}, rdw);
		@(posedge clk) anInitiated <= 1'b1;
		@(posedge clk) anInitiated <= 1'b0;
		rd;
		chkw({upperBits, 12'hD80}, rdw);
	endtask : t_write
	task t_restart;
		wr(16'h0000);
		chkb(1'b1, restartCnt == 1);
		@(posedge clk) anEnable <= 1'b0;
		wr(16'h0200);
		chkb(1'b1, restartCnt == 1);
		chkb(1'b0, fullDuplex);
		@(posedge clk) anEnable <= 1'b1;
		cyc(2);
		chkb(1'b1, fullDuplex);
	endtask : t_restart
	task t_col;
		wr(16'h0080);
		@(posedge clk) txEn <= 1'b1;
		cyc(51);
		chkb(1'b1, col);
		@(posedge clk) txEn <= 1'b0;
		cyc(8);
		chkb(1'b0, col);
		wr(16'h0000);
		@(posedge clk) txEn <= 1'b1;
		cyc(51);
		chkb(1'b0, col);
		@(posedge clk) txEn <= 1'b0;
	endtask : t_col
	task t_pin;
		@(posedge clk) interrupt_powerdown_pin_n <= 1'b0;
		cyc(10);
		chkb(1'b1, powerDown);
		@(posedge clk) interrupt_powerdown_pin_n <= 1'b1;
		cyc(10);
		rd;
		chkw({upperBits, 12'h800}, rdw);
		wr(16'h0000);
		chkb(1'b0, powerDown);
	endtask : t_pin
	task t_strap;
		@(posedge clk) soft_strap_default <= 1'b1;
		@(posedge clk) configDone <= 1'b1;
		@(posedge clk) configDone <= 1'b0;
		pbc_mgmt_master_inst.xfer(`PBC_OP_WRITE, ~phyAddr, 16'h0800, rdw);
		cyc(4);
		rd;
		chkw({upperBits, 12'h100}, rdw);
	endtask : t_strap
	initial
	begin
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		cyc(8);
		rd;
		chkw({upperBits, 12'h100}, rdw);
		t_write;
		t_restart;
		t_col;
		t_pin;
		t_strap;
		print_verdict;
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		failures++;
		print_verdict;
	end
endmodule : test_pbc_basic_control
`default_nettype wire
